// ==== core/ufl_uart.sv ====
// Top: host registers, framing engines, loopback and FIFO mode control
//
// Our own choices: the address map and the strobed register port.
`default_nettype none
module ufl_uart
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic cs_n,
    input wire logic [ufl_pkg::ADDR_W-1:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    input wire logic rx_in,
    output logic tx_out,
    output logic rts_n
);
    import ufl_pkg::*;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    logic [7:0] lctl_ff, fcr_ff, mcr_ff, txlvl_ff, rxlvl_ff, fch_ff, fcl_ff, rdata_ff;
    logic [7:0] nxt_lctl, nxt_fcr, nxt_mcr, nxt_txlvl, nxt_rxlvl, nxt_fch, nxt_fcl, nxt_rdata;
    logic [15:0] div_ff, nxt_div, bit_cyc;
    logic rts_n_ff, tx_ff, ext_ff, fen_ff, perr_ff, ovr_ff;
    logic nxt_rts_n, nxt_tx, nxt_perr, nxt_ovr;
    logic wr_hit, rd_hit, srst, stat_rd, ext_now, flush, rx_src;
    logic [CNT_W-1:0] limit, txf_cnt, rxf_cnt;
    logic [7:0] status, rx_trig, tx_trig;
    ufl_tx_state_type tx_st_ff, nxt_tx_st;
    ufl_rx_state_type rx_st_ff, nxt_rx_st;
    logic [15:0] tx_cnt_ff, nxt_tx_cnt, rx_cnt_ff, nxt_rx_cnt;
    logic [2:0] tx_idx_ff, nxt_tx_idx, rx_idx_ff, nxt_rx_idx;
    logic [7:0] tx_byte_ff, nxt_tx_byte, rx_byte_ff, nxt_rx_byte;
    logic tx_line_ff, nxt_tx_line, tx_stop_ff, nxt_tx_stop, tx_take;
    logic rx_prev_ff, rx_perr_ff, nxt_rx_perr, rx_push;

    ufl_stream_if #(.W(8)) txf_in ();
    ufl_stream_if #(.W(8)) txf_out ();
    ufl_stream_if #(.W(9)) skid_in ();
    ufl_stream_if #(.W(9)) skid_out ();
    ufl_stream_if #(.W(9)) rxf_out ();

    // Outputs straight from flip-flops
    assign rdata = rdata_ff;
    assign tx_out = tx_ff;
    assign rts_n = rts_n_ff;

    // Host strobe qualification
    assign wr_hit = wr && !cs_n;
    assign rd_hit = rd && !cs_n;
    assign srst = wr_hit && addr == A_LCTL && wdata[LC_SRST];
    assign stat_rd = rd_hit && addr == A_STAT;

    // Mode, depth limit and flush on any size change
    assign ext_now = |{txlvl_ff, rxlvl_ff, fch_ff, fcl_ff};
    assign flush = srst || (ext_ff != ext_now) || (fen_ff != fcr_ff[FCR_EN]);
    assign limit = !fcr_ff[FCR_EN] ? LIM_OFF : (ext_ff ? LIM_EXT : LIM_COMPAT);
    assign rx_trig = ufl_trig(ext_ff, rxlvl_ff, RX_TRIG_TAB[fcr_ff[FCR_RXT_LSB +: 2]]);
    assign tx_trig = ufl_trig(ext_ff, txlvl_ff, TX_TRIG_TAB[fcr_ff[FCR_TXT_LSB +: 2]]);
    assign status = {txf_cnt == limit, txf_cnt <= tx_trig, rxf_cnt >= rx_trig, ext_ff,
                     ovr_ff, perr_ff, txf_cnt == '0, rxf_cnt != '0};

    // Bit period never shorter than the fastest supported rate
    assign bit_cyc = (div_ff < MIN_BIT_CYC) ? MIN_BIT_CYC : div_ff;

    // Loopback steers the receiver to the transmit line
    assign rx_src = lctl_ff[LC_LOOP] ? tx_line_ff : rx_in;

    // Stream wiring: host writes, engines and host reads
    assign txf_in.valid = wr_hit && addr == A_DATA;
    assign txf_in.data = wdata;
    assign txf_out.ready = tx_take;
    assign skid_in.valid = rx_push;
    assign skid_in.data = {rx_perr_ff, rx_byte_ff};
    assign rxf_out.ready = rd_hit && addr == A_DATA;

    ufl_fifo #(.W(8), .DEPTH(FIFO_DEPTH)) u_txf (
        .clk(clk), .rst_n(rst_n), .flush(flush), .limit(limit),
        .in_s(txf_in), .out_s(txf_out), .count(txf_cnt));
    ufl_fifo #(.W(9), .DEPTH(SKID_DEPTH)) u_skid (
        .clk(clk), .rst_n(rst_n), .flush(flush), .limit(2'(SKID_DEPTH)),
        .in_s(skid_in), .out_s(skid_out), .count());
    ufl_fifo #(.W(9), .DEPTH(FIFO_DEPTH)) u_rxf (
        .clk(clk), .rst_n(rst_n), .flush(flush), .limit(limit),
        .in_s(skid_out), .out_s(rxf_out), .count(rxf_cnt));

    // Host register writes, reads and sticky flags
    always_comb
    begin
        nxt_lctl = lctl_ff;
        nxt_fcr = fcr_ff;
        nxt_mcr = mcr_ff;
        nxt_txlvl = txlvl_ff;
        nxt_rxlvl = rxlvl_ff;
        nxt_fch = fch_ff;
        nxt_fcl = fcl_ff;
        nxt_div = div_ff;
        nxt_rdata = REG_RESET;
        // Set wins over clear-on-read
        nxt_perr = (perr_ff && !stat_rd) || (rxf_out.ready && rxf_out.valid
                                             && rxf_out.data[PERR_BIT]);
        nxt_ovr = (ovr_ff && !stat_rd) || (rx_push && !skid_in.ready);
        if (srst)
        begin
            nxt_lctl = LCTL_RESET;
            nxt_fcr = REG_RESET;
            nxt_mcr = REG_RESET;
            nxt_txlvl = REG_RESET;
            nxt_rxlvl = REG_RESET;
            nxt_fch = REG_RESET;
            nxt_fcl = REG_RESET;
            nxt_div = DIV_RESET;
        end
        else if (wr_hit)
        begin
            case (addr)
                A_LCTL: nxt_lctl = wdata;
                A_FCR: nxt_fcr = wdata;
                A_MCR: nxt_mcr = wdata;
                A_TXLVL: nxt_txlvl = wdata;
                A_RXLVL: nxt_rxlvl = wdata;
                A_FCH: nxt_fch = wdata;
                A_FCL: nxt_fcl = wdata;
                A_DIVL: nxt_div[7:0] = wdata;
                A_DIVH: nxt_div[15:8] = wdata;
                default: nxt_div = div_ff;
            endcase
        end
        if (rd_hit)
        begin
            case (addr)
                A_DATA: nxt_rdata = rxf_out.valid ? rxf_out.data[7:0] : REG_RESET;
                A_LCTL: nxt_rdata = lctl_ff;
                A_FCR: nxt_rdata = fcr_ff;
                A_MCR: nxt_rdata = mcr_ff;
                A_STAT: nxt_rdata = status;
                A_TXLVL: nxt_rdata = txlvl_ff;
                A_RXLVL: nxt_rdata = rxlvl_ff;
                A_FCH: nxt_rdata = fch_ff;
                A_FCL: nxt_rdata = fcl_ff;
                A_DIVL: nxt_rdata = div_ff[7:0];
                A_DIVH: nxt_rdata = div_ff[15:8];
                default: nxt_rdata = REG_RESET;
            endcase
        end
        nxt_rts_n = !mcr_ff[MCR_RTS];
        nxt_tx = (lctl_ff[LC_LOOP] || !lctl_ff[LC_TX_EN]) ? 1'b1 : tx_line_ff;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            lctl_ff <= LCTL_RESET;
            fcr_ff <= REG_RESET;
            mcr_ff <= REG_RESET;
            txlvl_ff <= REG_RESET;
            rxlvl_ff <= REG_RESET;
            fch_ff <= REG_RESET;
            fcl_ff <= REG_RESET;
            div_ff <= DIV_RESET;
            rdata_ff <= REG_RESET;
            rts_n_ff <= 1'b1;
            tx_ff <= 1'b1;
            ext_ff <= 1'b0;
            fen_ff <= 1'b0;
            perr_ff <= 1'b0;
            ovr_ff <= 1'b0;
        end
        else
        begin
            lctl_ff <= nxt_lctl;
            fcr_ff <= nxt_fcr;
            mcr_ff <= nxt_mcr;
            txlvl_ff <= nxt_txlvl;
            rxlvl_ff <= nxt_rxlvl;
            fch_ff <= nxt_fch;
            fcl_ff <= nxt_fcl;
            div_ff <= nxt_div;
            rdata_ff <= nxt_rdata;
            rts_n_ff <= nxt_rts_n;
            tx_ff <= nxt_tx;
            ext_ff <= ext_now;
            fen_ff <= fcr_ff[FCR_EN];
            perr_ff <= nxt_perr;
            ovr_ff <= nxt_ovr;
        end
    end

    // Transmit framer: start, eight data bits, parity, one or two stops
    always_comb
    begin
        nxt_tx_st = tx_st_ff;
        nxt_tx_cnt = tx_cnt_ff;
        nxt_tx_idx = tx_idx_ff;
        nxt_tx_byte = tx_byte_ff;
        nxt_tx_line = tx_line_ff;
        nxt_tx_stop = tx_stop_ff;
        tx_take = 1'b0;
        if (tx_st_ff == TX_IDLE)
        begin
            nxt_tx_line = 1'b1;
            if (lctl_ff[LC_TX_EN] && txf_out.valid)
            begin
                tx_take = 1'b1;
                nxt_tx_byte = txf_out.data;
                nxt_tx_line = 1'b0;
                nxt_tx_cnt = bit_cyc - 1'b1;
                nxt_tx_st = TX_START;
            end
        end
        else if (tx_cnt_ff != '0)
            nxt_tx_cnt = tx_cnt_ff - 1'b1;
        else
        begin
            nxt_tx_cnt = bit_cyc - 1'b1;
            case (tx_st_ff)
                TX_START:
                begin
                    nxt_tx_idx = '0;
                    nxt_tx_line = tx_byte_ff[0];
                    nxt_tx_st = TX_DATA;
                end
                TX_DATA:
                begin
                    if (tx_idx_ff != LAST_BIT)
                    begin
                        nxt_tx_idx = tx_idx_ff + 1'b1;
                        nxt_tx_line = tx_byte_ff[nxt_tx_idx];
                    end
                    else if (lctl_ff[LC_PAR_EN])
                    begin
                        nxt_tx_line = ufl_parity(tx_byte_ff, lctl_ff[LC_PAR_ODD]);
                        nxt_tx_st = TX_PAR;
                    end
                    else
                    begin
                        nxt_tx_line = 1'b1;
                        nxt_tx_stop = lctl_ff[LC_STOP2];
                        nxt_tx_st = TX_STOP;
                    end
                end
                TX_PAR:
                begin
                    nxt_tx_line = 1'b1;
                    nxt_tx_stop = lctl_ff[LC_STOP2];
                    nxt_tx_st = TX_STOP;
                end
                TX_STOP:
                begin
                    nxt_tx_stop = 1'b0;
                    if (!tx_stop_ff)
                        nxt_tx_st = TX_IDLE;
                end
                default: nxt_tx_st = TX_IDLE;
            endcase
        end
    end

    // Receiver: falling edge, mid-bit confirm, centre sampling
    always_comb
    begin
        nxt_rx_st = rx_st_ff;
        nxt_rx_cnt = rx_cnt_ff;
        nxt_rx_idx = rx_idx_ff;
        nxt_rx_byte = rx_byte_ff;
        nxt_rx_perr = rx_perr_ff;
        rx_push = 1'b0;
        if (rx_st_ff == RX_IDLE)
        begin
            // Idle-high line makes a falling edge a start
            if (rx_prev_ff && !rx_src)
            begin
                nxt_rx_cnt = {1'b0, bit_cyc[15:1]} - 1'b1;
                nxt_rx_perr = 1'b0;
                nxt_rx_st = RX_START;
            end
        end
        else if (rx_cnt_ff != '0)
            nxt_rx_cnt = rx_cnt_ff - 1'b1;
        else
        begin
            nxt_rx_cnt = bit_cyc - 1'b1;
            case (rx_st_ff)
                RX_START:
                begin
                    nxt_rx_idx = '0;
                    nxt_rx_st = rx_src ? RX_IDLE : RX_DATA;
                end
                RX_DATA:
                begin
                    nxt_rx_byte[rx_idx_ff] = rx_src;
                    nxt_rx_idx = rx_idx_ff + 1'b1;
                    if (rx_idx_ff == LAST_BIT)
                        nxt_rx_st = lctl_ff[LC_PAR_EN] ? RX_PAR : RX_STOP;
                end
                RX_PAR:
                begin
                    nxt_rx_perr = rx_src != ufl_parity(rx_byte_ff, lctl_ff[LC_PAR_ODD]);
                    nxt_rx_st = RX_STOP;
                end
                RX_STOP:
                begin
                    rx_push = 1'b1;
                    nxt_rx_st = RX_IDLE;
                end
                default: nxt_rx_st = RX_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tx_st_ff <= TX_IDLE;
            tx_cnt_ff <= '0;
            tx_idx_ff <= '0;
            tx_byte_ff <= REG_RESET;
            tx_line_ff <= 1'b1;
            tx_stop_ff <= 1'b0;
            rx_st_ff <= RX_IDLE;
            rx_cnt_ff <= '0;
            rx_idx_ff <= '0;
            rx_byte_ff <= REG_RESET;
            rx_perr_ff <= 1'b0;
            rx_prev_ff <= 1'b1;
        end
        else
        begin
            tx_st_ff <= nxt_tx_st;
            tx_cnt_ff <= nxt_tx_cnt;
            tx_idx_ff <= nxt_tx_idx;
            tx_byte_ff <= nxt_tx_byte;
            tx_line_ff <= nxt_tx_line;
            tx_stop_ff <= nxt_tx_stop;
            rx_st_ff <= nxt_rx_st;
            rx_cnt_ff <= nxt_rx_cnt;
            rx_idx_ff <= nxt_rx_idx;
            rx_byte_ff <= nxt_rx_byte;
            rx_perr_ff <= nxt_rx_perr;
            rx_prev_ff <= rx_src;
        end
    end

    // Checks on request output, line levels, framing, access and mode
    property p_rts_low;
        wr_hit && addr == A_MCR && wdata[MCR_RTS] |=> mcr_ff[MCR_RTS] ##1 !rts_n_ff;
    endproperty
    a_rts_low: assert property (p_rts_low) else $error("request output not low");
    property p_rts_high;
        !mcr_ff[MCR_RTS] |=> rts_n_ff;
    endproperty
    a_rts_high: assert property (p_rts_high) else $error("request output not high");
    property p_loop_rx;
        lctl_ff[LC_LOOP] |-> rx_src == tx_line_ff;
    endproperty
    a_loop_rx: assert property (p_loop_rx) else $error("loopback not routed");
    property p_tx_idle;
        tx_st_ff == TX_IDLE |-> tx_line_ff;
    endproperty
    a_tx_idle: assert property (p_tx_idle) else $error("idle line not high");
    property p_tx_off;
        !lctl_ff[LC_TX_EN] || lctl_ff[LC_LOOP] |=> tx_ff;
    endproperty
    a_tx_off: assert property (p_tx_off) else $error("transmit pin driven while off");
    property p_start;
        tx_st_ff == TX_IDLE && nxt_tx_st == TX_START |=> !tx_line_ff [*8] ##1 !tx_line_ff;
    endproperty
    a_start: assert property (p_start) else $error("start bit too short");
    property p_par;
        tx_st_ff == TX_PAR |-> tx_line_ff == ufl_parity(tx_byte_ff, lctl_ff[LC_PAR_ODD]);
    endproperty
    a_par: assert property (p_par) else $error("wrong parity bit");
    property p_cs;
        cs_n |=> $stable(mcr_ff) && $stable(div_ff) && rdata_ff == REG_RESET;
    endproperty
    a_cs: assert property (p_cs) else $error("access taken without select");
    property p_ext;
        1'b1 |=> ext_ff == $past(ext_now);
    endproperty
    a_ext: assert property (p_ext) else $error("mode flag wrong");
    property p_flush;
        ext_ff != ext_now |=> txf_cnt == '0 && rxf_cnt == '0;
    endproperty
    a_flush: assert property (p_flush) else $error("fifos not flushed");
    property p_srst;
        srst |=> txlvl_ff == REG_RESET && fcl_ff == REG_RESET ##1 !ext_ff;
    endproperty
    a_srst: assert property (p_srst) else $error("soft reset left extended mode");
    property p_confirm;
        rx_st_ff == RX_START && rx_cnt_ff == '0 && rx_src |=> rx_st_ff == RX_IDLE;
    endproperty
    a_confirm: assert property (p_confirm) else $error("false start accepted");
endmodule
`default_nettype wire

// ==== core/ufl_pkg.sv ====
// Package: register map, field positions, timing constants and state types
`default_nettype none
package ufl_pkg;
    // Host register addresses
    localparam int ADDR_W = 4;
    localparam logic [3:0] A_DATA = 4'h0;
    localparam logic [3:0] A_LCTL = 4'h1;
    localparam logic [3:0] A_FCR = 4'h2;
    localparam logic [3:0] A_MCR = 4'h3;
    localparam logic [3:0] A_STAT = 4'h4;
    localparam logic [3:0] A_TXLVL = 4'h5;
    localparam logic [3:0] A_RXLVL = 4'h6;
    localparam logic [3:0] A_FCH = 4'h7;
    localparam logic [3:0] A_FCL = 4'h8;
    localparam logic [3:0] A_DIVL = 4'h9;
    localparam logic [3:0] A_DIVH = 4'ha;
    // Line control fields
    localparam int LC_PAR_EN = 0;
    localparam int LC_PAR_ODD = 1;
    localparam int LC_STOP2 = 2;
    localparam int LC_TX_EN = 3;
    localparam int LC_LOOP = 4;
    localparam int LC_SRST = 7;
    // FIFO control, modem control and status fields
    localparam int FCR_EN = 0;
    localparam int FCR_TXT_LSB = 4;
    localparam int FCR_RXT_LSB = 6;
    localparam int MCR_RTS = 1;
    localparam int PERR_BIT = 8;
    // Reset values
    localparam logic [7:0] LCTL_RESET = 8'h08;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [15:0] DIV_RESET = 16'h043d;
    // Timing: fastest bit rate sets the shortest bit period
    localparam longint CLK_HZ = 125_000_000;
    localparam longint EXT_MAX_BPS = 5_000_000;
    localparam logic [15:0] MIN_BIT_CYC = 16'((CLK_HZ + EXT_MAX_BPS - 1) / EXT_MAX_BPS);
    // FIFO sizes and trigger tables
    localparam int FIFO_DEPTH = 128;
    localparam int SKID_DEPTH = 2;
    localparam int CNT_W = 8;
    localparam logic [CNT_W-1:0] LIM_OFF = 8'h01;
    localparam logic [CNT_W-1:0] LIM_COMPAT = 8'h20;
    localparam logic [CNT_W-1:0] LIM_EXT = 8'h80;
    localparam logic [7:0] RX_TRIG_TAB [4] = '{8'h08, 8'h10, 8'h18, 8'h1c};
    localparam logic [7:0] TX_TRIG_TAB [4] = '{8'h10, 8'h08, 8'h18, 8'h1e};
    localparam logic [2:0] LAST_BIT = 3'h7;

    typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} ufl_tx_state_type;
    typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} ufl_rx_state_type;

    // Parity bit for a byte, even or odd
    function automatic logic ufl_parity(input logic [7:0] d, input logic odd);
        return (^d) ^ odd;
    endfunction

    // Effective trigger level: register in extended mode, table otherwise
    function automatic logic [7:0] ufl_trig(input logic ext, input logic [7:0] lvl,
                                            input logic [7:0] compat);
        if (!ext)
            return compat;
        return (lvl == REG_RESET) ? 8'h01 : lvl;
    endfunction
endpackage
`default_nettype wire

// ==== core/ufl_stream_if.sv ====
// Interface: valid/ready stream of W-bit words between the transceiver's modules
`default_nettype none
interface ufl_stream_if #(parameter int W = 8);
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// ==== core/ufl_fifo.sv ====
// Module: flip-flop FIFO with run-time fill limit and flush
`default_nettype none
module ufl_fifo #(
    parameter int W = 8,
    parameter int DEPTH = 128
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic flush,
    input wire logic [$clog2(DEPTH+1)-1:0] limit,
    ufl_stream_if.snk in_s,
    ufl_stream_if.src out_s,
    output logic [$clog2(DEPTH+1)-1:0] count
);
    localparam int CW = $clog2(DEPTH+1);
    localparam int PW = $clog2(DEPTH);

    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
        $error("ufl_fifo: DEPTH must be a power of two, at least 2");

    logic [W-1:0] mem_ff [DEPTH];
    logic [W-1:0] nxt_mem [DEPTH];
    logic [PW-1:0] rp_ff, wp_ff, nxt_rp, nxt_wp;
    logic [CW-1:0] cnt_ff, nxt_cnt;
    logic push, pop;

    // Handshake terms; limit shrinks the usable depth
    assign in_s.ready = (cnt_ff < limit) && (cnt_ff < CW'(DEPTH));
    assign out_s.valid = (cnt_ff != '0);
    assign out_s.data = mem_ff[rp_ff];
    assign count = cnt_ff;
    assign push = in_s.valid && in_s.ready;
    assign pop = out_s.valid && out_s.ready;

    // Next pointers, count and storage
    always_comb
    begin
        nxt_mem = mem_ff;
        nxt_rp = rp_ff;
        nxt_wp = wp_ff;
        nxt_cnt = cnt_ff;
        if (flush)
        begin
            nxt_rp = '0;
            nxt_wp = '0;
            nxt_cnt = '0;
        end
        else
        begin
            if (push)
            begin
                nxt_mem[wp_ff] = in_s.data;
                nxt_wp = wp_ff + 1'b1;
            end
            if (pop)
                nxt_rp = rp_ff + 1'b1;
            if (push && !pop)
                nxt_cnt = cnt_ff + 1'b1;
            else if (pop && !push)
                nxt_cnt = cnt_ff - 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rp_ff <= '0;
            wp_ff <= '0;
            cnt_ff <= '0;
            for (int i = 0; i < DEPTH; i++)
                mem_ff[i] <= '0;
        end
        else
        begin
            rp_ff <= nxt_rp;
            wp_ff <= nxt_wp;
            cnt_ff <= nxt_cnt;
            mem_ff <= nxt_mem;
        end
    end

    property p_fifo_fill;
        @(posedge clk) disable iff (!rst_n)
        push && !pop && !flush |=> cnt_ff == $past(cnt_ff) + 1'b1 && cnt_ff <= CW'(DEPTH);
    endproperty
    a_fifo_fill: assert property (p_fifo_fill) else $error("fifo count did not grow");
endmodule
`default_nettype wire

// ==== tb/ufl_serial_peer.sv ====
// Far-end serial device model
`default_nettype none
module ufl_serial_peer #(parameter int BITC = 25)
(
    input wire logic clk,
    output logic line
);
    timeunit 1ns;
    timeprecision 1ps;
    initial line = 1'h1;
    // Start, 8 data LSB first, parity, stop; bad flips parity
    task automatic send(input logic [7:0] b, input logic bad);
        logic [10:0] f;
        f = {1'h1, ^b ^ bad, b, 1'h0};
        for (int i = 0; i < 11; i++)
        begin
            @(posedge clk);
            line <= f[i];
            repeat (BITC - 1) @(posedge clk);
        end
    endtask
endmodule
`default_nettype wire

// ==== tb/ufl_uart_tb.sv ====
// Testbench for the transceiver
`default_nettype none
module ufl_uart_tb;
    import ufl_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int B = 25;
    logic clk = 0, rst_n = 0, cs_n = 0, wr = 0, rd = 0;
    logic [3:0] addr = '0;
    logic [7:0] wdata = '0, rdata, v, b;
    logic tx_out, rts_n, rx_line;
    logic [10:0] fr;
    logic [7:0] q[$];
    logic [31:0] seed = 32'h09d929d5;
    int mismatches = 0, n_checks = 0, cyc = 0;
    always #4 clk = ~clk;
    ufl_uart DUT (.clk(clk), .rst_n(rst_n), .cs_n(cs_n), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .rx_in(rx_line), .tx_out(tx_out), .rts_n(rts_n));
    ufl_serial_peer #(.BITC(B)) peer (.clk(clk), .line(rx_line));
    // Cycle ceiling against hangs
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 5000)
        begin
            mismatches++;
            stop_test();
        end
    end
    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
        n_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("unexpected at %0t: %s %h/%h", $time, m, got, exp);
        end
    endtask
    task automatic wreg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'h1;
        @(posedge clk);
        wr <= 1'h0;
    endtask
    task automatic rreg(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'h1;
        @(posedge clk);
        rd <= 1'h0;
        @(negedge clk);
        d = rdata;
    endtask
    // Wait for a start edge, sample each bit at its centre
    task automatic get_tx(output logic [10:0] f);
        for (int i = 0; i < 2000 && tx_out; i++)
            @(posedge clk);
        repeat (B / 2 - 1) @(posedge clk);
        for (int i = 0; i < 11; i++)
        begin
            @(negedge clk);
            f[i] = tx_out;
            repeat (B) @(posedge clk);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // Main sequence
    initial
    begin
        repeat (4) @(posedge clk);
        rst_n <= 1'h1;
        chk({6'h0, tx_out, rts_n}, 8'h03, "reset pins");
        rreg(A_LCTL, v);
        chk(v, LCTL_RESET, "lctl");
        wreg(A_MCR, 8'h02);
        repeat (2) @(negedge clk);
        chk({7'h0, rts_n}, 8'h00, "rts on");
        @(posedge clk);
        cs_n <= 1'h1;
        wreg(A_MCR, 8'h00);
        cs_n <= 1'h0;
        repeat (2) @(negedge clk);
        chk({7'h0, rts_n}, 8'h00, "deselected");
        wreg(A_TXLVL, rnd() | 8'h01);
        rreg(A_STAT, v);
        chk(v & 8'h10, 8'h10, "ext");
        wreg(A_TXLVL, 8'h00);
        rreg(A_STAT, v);
        chk(v & 8'h10, 8'h00, "compat");
        $display("test regs done");
        wreg(A_LCTL, 8'h00);
        wreg(A_DATA, rnd());
        wreg(A_DATA, rnd());
        rreg(A_STAT, v);
        chk(v & 8'h82, 8'h80, "full");
        chk({7'h0, tx_out}, 8'h01, "tx off");
        wreg(A_LCTL, 8'h80);
        rreg(A_LCTL, v);
        chk(v, LCTL_RESET, "soft lctl");
        rreg(A_STAT, v);
        chk(v & 8'h82, 8'h02, "flushed");
        chk({7'h0, rts_n}, 8'h01, "rts off");
        $display("test fill done");
        wreg(A_DIVL, 8'h19);
        wreg(A_DIVH, 8'h00);
        wreg(A_LCTL, 8'h0f);
        b = rnd();
        wreg(A_DATA, b);
        get_tx(fr);
        chk(fr[8:1], b, "tx data");
        chk({5'h0, fr[10:9], fr[0]}, {5'h0, 1'h1, ~^b, 1'h0}, "frame");
        wreg(A_LCTL, 8'h09);
        for (int i = 0; i < 2; i++)
        begin
            b = rnd();
            q.push_back(b);
            peer.send(b, i[0]);
            repeat (B) @(posedge clk);
            rreg(A_STAT, v);
            chk(v & 8'h01, 8'h01, "rx avail");
            rreg(A_DATA, v);
            chk(v, q.pop_front(), "rx data");
            rreg(A_STAT, v);
            chk(v & 8'h05, i ? 8'h04 : 8'h00, "rx stat");
        end
        $display("test serial done");
        wreg(A_LCTL, 8'h19);
        b = rnd();
        q.push_back(b);
        wreg(A_DATA, b);
        v = 8'h01;
        repeat (12 * B)
        begin
            @(negedge clk);
            v = v & {7'h0, tx_out};
        end
        chk(v, 8'h01, "loop pin");
        rreg(A_DATA, v);
        chk(v, q.pop_front(), "loop data");
        $display("test loop done");
        wreg(A_LCTL, 8'h00);
        wreg(A_FCR, 8'h01);
        wreg(A_DATA, rnd());
        wreg(A_DATA, rnd());
        rreg(A_STAT, v);
        chk(v & 8'hc2, 8'h40, "compat depth");
        wreg(A_FCR, 8'h00);
        rreg(A_STAT, v);
        chk(v & 8'h82, 8'h02, "size flush");
        $display("test fifo done");
        stop_test();
    end
endmodule
`default_nettype wire
